// [core/timer_cc_pkg.sv]
package timer_cc_pkg;

	// ************************************************************
	// register map (byte addresses, one aligned word each)
	// ************************************************************
	localparam int NUM_CH = 2;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HIGH = 8'h04;
	localparam logic [7:0] OFS_LOW = 8'h08;
	localparam logic [7:0] CH_STRIDE = 8'h0C;
	localparam logic [7:0] ADDR_CNT_CTRL = 8'h18;
	localparam logic [7:0] ADDR_MODULO = 8'h1C;
	localparam logic [7:0] ADDR_COUNT = 8'h20;

	// ************************************************************
	// field layouts
	// ************************************************************
	typedef struct packed {
		logic channel_event_flag;
		logic irq_en;
		logic buffered_mode_sel;
		logic compare_mode_sel;
		logic edge_level_sel_hi;
		logic edge_level_sel_lo;
		logic toggle_on_wrap;
		logic full_duty_force;
	} chan_ctrl_t;

	typedef struct packed {
		logic counter_wrap_flag;
		logic rsvd_hi;
		logic stop;
		logic clear;
		logic rsvd_lo;
		logic [2:0] prescale_sel;
	} cnt_ctrl_t;

	localparam int FLAG_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CNT_CTRL_RESET = 8'h20;
	localparam logic [15:0] MODULO_RESET = 16'hFFFF;
	localparam logic [2:0] PRESCALE_UNUSED = 3'h7;
	localparam int PRESCALE_W = 6;

	// ************************************************************
	// edge/level codes
	// ************************************************************
	localparam logic [1:0] ELS_OFF = 2'h0;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_CLEAR = 2'h2;
	localparam logic [1:0] ELS_SET = 2'h3;

endpackage : timer_cc_pkg

// [core/pin_sync.sv]
module pin_sync (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// raw pin level
	input wire logic pin_in,
	// synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);

	logic meta;
	logic stable;
	logic prev;
	logic next_meta;
	logic next_stable;
	logic next_prev;

	always_comb begin
		next_meta = pin_in;
		next_stable = meta;
		next_prev = stable;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			meta <= 1'b0;
			stable <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= next_meta;
			stable <= next_stable;
			prev <= next_prev;
		end
	end

	// edges look only at the second and third stages
	assign level = stable;
	assign rise = stable & ~prev;
	assign fall = ~stable & prev;

endmodule : pin_sync

// [core/timer_channel_capture_compare.sv]
// Functional notes
// R1: both edge/level bits zero releases the pin to port; internal output state preset.
// R2: with edge/level zero, compare_mode_sel 0 presets output high, 1 presets low.
// R3: both mode bits zero: capture on rising (01), falling (10) or either (11) edge.
// R4: unbuffered compare: 00 flag only, 01 toggle, 10 clear, 11 set on match.
// R5: buffered mode: 01 toggle, 10 clear, 11 set output on match.
// R6: reset clears edge/level bits of every channel.
// R7: outside source keeps pin stable two bus clocks before capture is enabled.
// R8: toggle_on_wrap in compare mode toggles output at each overflow; cleared by reset.
// R9: overflow action wins over a same-cycle compare action when toggle_on_wrap set.
// R10: toggle_on_wrap plus clear action plus full_duty_force gives constant high.
// R11: full_duty_force changes take effect only from the next period.
// R12: clear action with toggle_on_wrap off and no force yields constant low.
// R13: value register holds capture or match value; not initialised by reset.
// R14: capture mode: high byte read blocks captures until low byte read.
// R15: compare mode: high byte write blocks matches and flag until low byte write.
// R16: counter overflows at modulo, sets wrap flag, restarts from zero next tick.
// R17: flag sets on active edge in capture, on counter equality in compare.
// R18: buffered bit only on channel 0; it disables channel 1 control and pin.
// R19: flag clears by read-with-flag-set then write 0; new event keeps it set.
// R20: in buffered mode the last written value register becomes active at overflow.
// R21: interrupt request while flag and enable are both set.
module timer_channel_capture_compare (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic [timer_cc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel pins
	input wire logic [timer_cc_pkg::NUM_CH-1:0] chan_pin_in,
	output logic [timer_cc_pkg::NUM_CH-1:0] chan_pin_out,
	output logic [timer_cc_pkg::NUM_CH-1:0] chan_pin_oe,
	// interrupt requests
	output logic [timer_cc_pkg::NUM_CH-1:0] chan_irq
);

	// ************************************************************
	// apb handshake: one wait state, pready from a flop
	// ************************************************************
	logic access, commit, next_pready, next_pslverr, rd_hit;
	logic [31:0] next_prdata, rd_mux;

	assign access = psel & penable;
	assign commit = access & pready;

	// ************************************************************
	// counter, prescaler and modulo
	// ************************************************************
	timer_cc_pkg::cnt_ctrl_t cctl, next_cctl;
	logic [15:0] count, next_count, modulo, next_modulo;
	logic [timer_cc_pkg::PRESCALE_W-1:0] pres, next_pres, pres_mask;
	logic wrap_armed, next_wrap_armed, tick, wrap_hit, wr_cctl, rd_cctl, wr_mod;

	assign wr_cctl = commit & pwrite & (paddr == timer_cc_pkg::ADDR_CNT_CTRL);
	assign rd_cctl = commit & ~pwrite & (paddr == timer_cc_pkg::ADDR_CNT_CTRL);
	assign wr_mod = commit & pwrite & (paddr == timer_cc_pkg::ADDR_MODULO);
	assign pres_mask = timer_cc_pkg::PRESCALE_W'((7'h01 << cctl.prescale_sel) - 7'h01);
	assign tick = ~cctl.stop & (cctl.prescale_sel != timer_cc_pkg::PRESCALE_UNUSED)
		& ((pres & pres_mask) == pres_mask);
	assign wrap_hit = tick & (count == modulo); // R16

	always_comb begin
		next_cctl = cctl;
		next_count = count;
		next_modulo = modulo;
		next_pres = cctl.stop ? pres : pres + 1'b1;
		next_wrap_armed = wrap_armed;
		if (tick) begin
			next_count = wrap_hit ? 16'h0000 : count + 16'h0001; // R16
		end
		if (wr_mod) begin
			next_modulo = pwdata[15:0];
		end
		if (rd_cctl && cctl.counter_wrap_flag) begin
			next_wrap_armed = 1'b1;
		end
		if (wr_cctl) begin
			next_cctl.stop = pwdata[5];
			next_cctl.prescale_sel = pwdata[2:0];
			if (wrap_armed && !pwdata[timer_cc_pkg::FLAG_BIT]) begin
				next_cctl.counter_wrap_flag = 1'b0;
				next_wrap_armed = 1'b0;
			end
			// the clear bit never stores; it only restarts counting from zero
			if (pwdata[4]) begin
				next_count = 16'h0000;
				next_pres = '0;
			end
		end
		if (wrap_hit) begin
			next_cctl.counter_wrap_flag = 1'b1; // R16
			next_wrap_armed = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cctl <= timer_cc_pkg::cnt_ctrl_t'(timer_cc_pkg::CNT_CTRL_RESET);
			count <= 16'h0000;
			modulo <= timer_cc_pkg::MODULO_RESET;
			pres <= '0;
			wrap_armed <= 1'b0;
		end else begin
			cctl <= next_cctl;
			count <= next_count;
			modulo <= next_modulo;
			pres <= next_pres;
			wrap_armed <= next_wrap_armed;
		end
	end

	// ************************************************************
	// buffered pair: which value register drives channel 0
	// ************************************************************
	timer_cc_pkg::chan_ctrl_t ctrl_v [timer_cc_pkg::NUM_CH];
	logic [15:0] val_v [timer_cc_pkg::NUM_CH];
	logic [timer_cc_pkg::NUM_CH-1:0] wlock_v, wr_low_v;
	logic linked, active_sel, next_active_sel, last_written, next_last_written;

	assign linked = ctrl_v[0].buffered_mode_sel;

	always_comb begin
		next_active_sel = active_sel;
		next_last_written = last_written;
		if (!linked) begin
			next_active_sel = 1'b0;
			next_last_written = 1'b0;
		end else begin
			if (wr_low_v[1]) begin
				next_last_written = 1'b1;
			end else if (wr_low_v[0]) begin
				next_last_written = 1'b0;
			end
			if (wrap_hit) begin
				next_active_sel = next_last_written; // R20
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			active_sel <= 1'b0;
			last_written <= 1'b0;
		end else begin
			active_sel <= next_active_sel;
			last_written <= next_last_written;
		end
	end

	// ************************************************************
	// channels
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < timer_cc_pkg::NUM_CH; gi++) begin : g_ch
			localparam logic [7:0] A_BASE = 8'(gi) * timer_cc_pkg::CH_STRIDE;
			timer_cc_pkg::chan_ctrl_t ctrl, next_ctrl;
			logic [15:0] val, next_val, match_val;
			logic [1:0] els;
			logic armed, next_armed, rlock, next_rlock, wlock, next_wlock, max_on, next_max_on;
			logic out, next_out, next_oe, next_irq, rise, fall, disabled, is_cmp, active, cap_mode;
			logic edge_hit, match_hit, lock_hit, evt, wr_ctrl, rd_ctrl, wr_hi, wr_lo, rd_hi, rd_lo;

			pin_sync u_sync (
				.clk(clk),
				.reset(reset),
				.pin_in(chan_pin_in[gi]),
				.level(),
				.rise(rise),
				.fall(fall)
			);

			assign els = {ctrl.edge_level_sel_hi, ctrl.edge_level_sel_lo};
			assign disabled = (gi != 0) & linked; // R18
			assign is_cmp = ctrl.buffered_mode_sel | ctrl.compare_mode_sel;
			assign active = (els != timer_cc_pkg::ELS_OFF) & ~disabled;
			assign cap_mode = active & ~is_cmp; // R3
			assign wr_ctrl = commit & pwrite & (paddr == A_BASE + timer_cc_pkg::OFS_CTRL);
			assign rd_ctrl = commit & ~pwrite & (paddr == A_BASE + timer_cc_pkg::OFS_CTRL);
			assign wr_hi = commit & pwrite & (paddr == A_BASE + timer_cc_pkg::OFS_HIGH);
			assign wr_lo = commit & pwrite & (paddr == A_BASE + timer_cc_pkg::OFS_LOW);
			assign rd_hi = commit & ~pwrite & (paddr == A_BASE + timer_cc_pkg::OFS_HIGH);
			assign rd_lo = commit & ~pwrite & (paddr == A_BASE + timer_cc_pkg::OFS_LOW);

			// captures stop while the counter is stopped or the high byte is held
			assign edge_hit = cap_mode & ~rlock & ~cctl.stop
				& ((els[0] & rise) | (els[1] & fall)); // R3 R14
			assign match_val = (active_sel && gi == 0) ? val_v[1] : val;
			assign lock_hit = (active_sel && gi == 0) ? wlock_v[1] : wlock;
			assign match_hit = is_cmp & ~disabled & tick & (count == match_val) & ~lock_hit; // R15 R17
			assign evt = edge_hit | match_hit; // R17

			always_comb begin
				next_ctrl = ctrl;
				next_val = val;
				next_armed = armed;
				next_rlock = rlock;
				next_wlock = wlock;
				next_max_on = max_on;
				next_out = out;
				if (rd_ctrl && ctrl.channel_event_flag && !disabled) begin
					next_armed = 1'b1;
				end
				if (wr_ctrl && !disabled) begin
					next_ctrl = timer_cc_pkg::chan_ctrl_t'(pwdata[7:0]);
					next_ctrl.channel_event_flag = ctrl.channel_event_flag;
					if (gi != 0) begin
						next_ctrl.buffered_mode_sel = 1'b0; // R18
					end
					if (armed && !pwdata[timer_cc_pkg::FLAG_BIT]) begin
						next_ctrl.channel_event_flag = 1'b0; // R19
					end
					next_armed = 1'b0;
				end
				if (evt) begin
					next_ctrl.channel_event_flag = 1'b1; // R19
					next_armed = 1'b0;
				end
				if (wr_hi) begin
					next_val[15:8] = pwdata[7:0];
					next_wlock = is_cmp; // R15
				end
				if (wr_lo) begin
					next_val[7:0] = pwdata[7:0];
					next_wlock = 1'b0; // R15
				end
				if (rd_hi && cap_mode) begin
					next_rlock = 1'b1; // R14
				end
				if (rd_lo) begin
					next_rlock = 1'b0; // R14
				end
				if (edge_hit) begin
					next_val = count; // R13
				end
				if (wrap_hit) begin
					next_max_on = ctrl.full_duty_force; // R11
				end
				if (els == timer_cc_pkg::ELS_OFF) begin
					next_out = ~ctrl.compare_mode_sel; // R1 R2
				end else if (is_cmp) begin
					if (ctrl.toggle_on_wrap && els == timer_cc_pkg::ELS_CLEAR && next_max_on) begin
						next_out = 1'b1; // R10 R11
					end else if (wrap_hit && ctrl.toggle_on_wrap) begin
						next_out = ~out; // R8 R9
					end else if (match_hit) begin
						unique case (els)
							timer_cc_pkg::ELS_TOGGLE: next_out = ~out; // R4 R5
							timer_cc_pkg::ELS_CLEAR: next_out = 1'b0; // R4 R5 R12
							timer_cc_pkg::ELS_SET: next_out = 1'b1; // R4 R5
							timer_cc_pkg::ELS_OFF: next_out = out;
						endcase
					end
				end
				next_oe = active & is_cmp; // R1 R18
				next_irq = next_ctrl.channel_event_flag & next_ctrl.irq_en; // R21
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					ctrl <= timer_cc_pkg::chan_ctrl_t'(timer_cc_pkg::CTRL_RESET); // R6 R8
					armed <= 1'b0;
					rlock <= 1'b0;
					wlock <= 1'b0;
					max_on <= 1'b0;
					out <= 1'b1;
					chan_pin_oe[gi] <= 1'b0;
					chan_irq[gi] <= 1'b0;
				end else begin
					ctrl <= next_ctrl;
					armed <= next_armed;
					rlock <= next_rlock;
					wlock <= next_wlock;
					max_on <= next_max_on;
					out <= next_out;
					chan_pin_oe[gi] <= next_oe;
					chan_irq[gi] <= next_irq;
				end
			end

			// the value register is data, not control: reset leaves it alone
			always_ff @(posedge clk) begin
				val <= next_val; // R13
			end

			assign chan_pin_out[gi] = out;
			assign ctrl_v[gi] = disabled ? timer_cc_pkg::chan_ctrl_t'(8'h00) : ctrl;
			assign val_v[gi] = val;
			assign wlock_v[gi] = wlock;
			assign wr_low_v[gi] = wr_lo;
		end
	endgenerate

	// ************************************************************
	// read mux and apb answer
	// ************************************************************
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (paddr)
			timer_cc_pkg::OFS_CTRL: rd_mux[7:0] = ctrl_v[0];
			timer_cc_pkg::OFS_HIGH: rd_mux[7:0] = val_v[0][15:8];
			timer_cc_pkg::OFS_LOW: rd_mux[7:0] = val_v[0][7:0];
			timer_cc_pkg::CH_STRIDE + timer_cc_pkg::OFS_CTRL: rd_mux[7:0] = ctrl_v[1];
			timer_cc_pkg::CH_STRIDE + timer_cc_pkg::OFS_HIGH: rd_mux[7:0] = val_v[1][15:8];
			timer_cc_pkg::CH_STRIDE + timer_cc_pkg::OFS_LOW: rd_mux[7:0] = val_v[1][7:0];
			timer_cc_pkg::ADDR_CNT_CTRL: rd_mux[7:0] = cctl; // clear and spare bits never store
			timer_cc_pkg::ADDR_MODULO: rd_mux[15:0] = modulo;
			timer_cc_pkg::ADDR_COUNT: rd_mux[15:0] = count;
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		next_pready = access & ~pready;
		next_pslverr = access & ~pready & ~rd_hit;
		next_prdata = (access && !pready) ? (pwrite ? 32'h0000_0000 : rd_mux) : prdata;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

endmodule : timer_channel_capture_compare

// [verification/pin_source.sv]
// ************************************************************
// far side of the channel pins: an outside source plus the wire
// ************************************************************
module pin_source (
	// level the outside source offers
	input wire logic [timer_cc_pkg::NUM_CH-1:0] ext,
	// block side of the pins
	input wire logic [timer_cc_pkg::NUM_CH-1:0] pin_out,
	input wire logic [timer_cc_pkg::NUM_CH-1:0] pin_oe,
	// resolved wire level fed back to the block
	output logic [timer_cc_pkg::NUM_CH-1:0] pin_in
);
	// the block wins where it drives; the source is weak and yields
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pin_source

// [verification/timer_cc_monitor.sv]
module timer_cc_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb
	input wire logic [timer_cc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	// channel side
	input wire logic [timer_cc_pkg::NUM_CH-1:0] chan_pin_oe,
	input wire logic [timer_cc_pkg::NUM_CH-1:0] chan_irq
);
	logic wr_done;
	logic ctl0_wr;
	assign wr_done = psel && penable && pready && pwrite;
	assign ctl0_wr = wr_done && (paddr == timer_cc_pkg::OFS_CTRL);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// ************************************************************
	// sequences
	// ************************************************************
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wait;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence
	// ************************************************************
	// properties
	// ************************************************************
	property p_ready_wait;
		s_setup ##1 psel && penable |-> s_wait;
	endproperty
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	property p_decode;
		pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > timer_cc_pkg::ADDR_COUNT);
	endproperty
	property p_ready_cause;
		pready |-> psel && penable && $past(psel && penable);
	endproperty
	// pin ownership only moves through a control write
	property p_oe_cause;
		$changed(chan_pin_oe) |-> $past(wr_done) || $past(wr_done, 2);
	endproperty
	property p_irq_fall;
		$fell(chan_irq[0]) |-> $past(ctl0_wr) || $past(ctl0_wr, 2) || $past(ctl0_wr, 3);
	endproperty
	property p_reset_oe;
		$fell(reset) |-> chan_pin_oe == 2'h0 && chan_irq == 2'h0;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	a_decode: assert property (p_decode) else $error("address decode wrong");
	a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved unasked");
	a_irq_fall: assert property (p_irq_fall) else $error("request dropped unasked");
	a_reset_oe: assert property (p_reset_oe) else $error("pin or request live at reset");
endmodule : timer_cc_monitor

bind timer_channel_capture_compare timer_cc_monitor timer_cc_monitor_inst (
	.clk(clk),
	.reset(reset),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pready(pready),
	.pslverr(pslverr),
	.chan_pin_oe(chan_pin_oe),
	.chan_irq(chan_irq)
);

// [verification/timer_channel_capture_compare_tb.sv]
module timer_channel_capture_compare_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_C0 = timer_cc_pkg::OFS_CTRL;
	localparam logic [7:0] A_H0 = timer_cc_pkg::OFS_HIGH;
	localparam logic [7:0] A_L0 = timer_cc_pkg::OFS_LOW;
	localparam logic [7:0] A_C1 = timer_cc_pkg::OFS_CTRL + timer_cc_pkg::CH_STRIDE;
	localparam logic [7:0] A_H1 = timer_cc_pkg::OFS_HIGH + timer_cc_pkg::CH_STRIDE;
	localparam logic [7:0] A_L1 = timer_cc_pkg::OFS_LOW + timer_cc_pkg::CH_STRIDE;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] pin_in, pin_out, pin_oe, irq, ext;
	logic [15:0] cnt;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;

	timer_channel_capture_compare timer_channel_capture_compare_inst (.clk(clk), .reset(reset),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_pin_in(pin_in),
		.chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .chan_irq(irq));
	pin_source pin_source_inst (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ************************************************************
	// bus and compare helpers
	// ************************************************************
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// pready is judged at a rising edge; only the bench timeout ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : wait_cyc
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bit_chk(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask : bit_chk
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 8'h00);
		chk(nm, e, rd);
	endtask : rd_chk
	// counts high cycles of channel 0 output over n cycles
	task automatic ones(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(negedge clk);
			k += int'(pin_out[0] === 1'b1);
		end
	endtask : ones
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		rd_chk("ctrl0", A_C0, 32'h0000_0000);
		rd_chk("cnt_ctrl", timer_cc_pkg::ADDR_CNT_CTRL, {24'h0, timer_cc_pkg::CNT_CTRL_RESET});
		rd_chk("modulo", timer_cc_pkg::ADDR_MODULO, {16'h0, timer_cc_pkg::MODULO_RESET});
		bit_chk("oe0", 1'b0, pin_oe[0]);
		apb(8'h40, 1'b0, 8'h00);
		bit_chk("slverr", 1'b1, err);
		wr(A_C0, 8'h10);
		wait_cyc(3);
		bit_chk("preset low", 1'b0, pin_out[0]);
		bit_chk("port owns pin", 1'b0, pin_oe[0]);
		wr(A_C0, 8'h00);
		wait_cyc(3);
		bit_chk("preset high", 1'b1, pin_out[0]);
		$display("test reset and preset done");
	endtask : t_reset
	task automatic t_capture;
		logic [1:0] c;
		wr(timer_cc_pkg::ADDR_CNT_CTRL, 8'h00);
		wait_cyc(37);
		wr(timer_cc_pkg::ADDR_CNT_CTRL, 8'h07);
		apb(timer_cc_pkg::ADDR_COUNT, 1'b0, 8'h00);
		cnt = rd[15:0];
		for (int i = 1; i < 4; i++) begin
			c = 2'(i);
			wr(A_C0, {4'h4, c, 2'h0});
			ext[0] <= 1'b1;
			wait_cyc(8);
			rd_chk("rise flag", A_C0, {24'h0, c[0], 3'h4, c, 2'h0});
			bit_chk("irq", c[0], irq[0]);
			wr(A_C0, {4'h4, c, 2'h0});
			wait_cyc(3);
			bit_chk("irq cleared", 1'b0, irq[0]);
			@(posedge clk);
			ext[0] <= 1'b0;
			wait_cyc(8);
			rd_chk("fall flag", A_C0, {24'h0, c[1], 3'h4, c, 2'h0});
			wr(A_C0, {4'h4, c, 2'h0});
		end
		rd_chk("cap hi", A_H0, {24'h0, cnt[15:8]});
		rd_chk("cap lo", A_L0, {24'h0, cnt[7:0]});
		apb(A_H0, 1'b0, 8'h00);
		wr(timer_cc_pkg::ADDR_CNT_CTRL, 8'h00);
		wr(timer_cc_pkg::ADDR_CNT_CTRL, 8'h07);
		ext[0] <= 1'b1;
		wait_cyc(8);
		rd_chk("blocked lo", A_L0, {24'h0, cnt[7:0]});
		wr(A_C0, 8'h00);
		$display("test capture done");
	endtask : t_capture
	task automatic t_compare;
		int k;
		logic prev;
		wr(timer_cc_pkg::ADDR_CNT_CTRL, 8'h30);
		wr(timer_cc_pkg::ADDR_MODULO, 8'h13);
		wr(A_H0, 8'h00);
		wr(A_L0, 8'h05);
		wr(timer_cc_pkg::ADDR_CNT_CTRL, 8'h00);
		wr(A_C0, 8'h10);
		wait_cyc(25);
		rd_chk("soft cmp", A_C0, 32'h0000_0090);
		bit_chk("soft oe", 1'b0, pin_oe[0]);
		rd_chk("wrap flag", timer_cc_pkg::ADDR_CNT_CTRL, 32'h0000_0080);
		wr(A_C0, 8'h1C);
		wait_cyc(25);
		bit_chk("set", 1'b1, pin_out[0]);
		bit_chk("set oe", 1'b1, pin_oe[0]);
		wr(A_C0, 8'h14);
		wait_cyc(25);
		prev = pin_out[0];
		wait_cyc(20);
		bit_chk("toggle", ~prev, pin_out[0]);
		wr(A_C0, 8'h18);
		wait_cyc(25);
		ones(20, k);
		chk("zero duty", 32'h0000_0000, k);
		wr(A_C0, 8'h1A);
		wait_cyc(25);
		ones(20, k);
		chk("pwm ones", 32'h0000_0006, k);
		wr(A_C0, 8'h1B);
		wait_cyc(45);
		ones(20, k);
		chk("full duty", 32'h0000_0014, k);
		wr(A_C0, 8'h18);
		wr(A_H0, 8'h00);
		apb(A_C0, 1'b0, 8'h00);
		wr(A_C0, 8'h18);
		wait_cyc(45);
		rd_chk("locked", A_C0, 32'h0000_0018);
		wr(A_L0, 8'h05);
		wait_cyc(25);
		rd_chk("unlocked", A_C0, 32'h0000_0098);
		wr(A_L0, 8'h13);
		wr(A_C0, 8'h1E);
		wait_cyc(25);
		ones(40, k);
		chk("wrap wins", 32'h0000_0014, k);
		$display("test compare done");
	endtask : t_compare
	task automatic t_link;
		int k;
		wr(A_C1, 8'h1C);
		wait_cyc(3);
		bit_chk("ch1 oe", 1'b1, pin_oe[1]);
		wr(A_C0, 8'h38);
		wait_cyc(3);
		bit_chk("ch1 freed", 1'b0, pin_oe[1]);
		rd_chk("ch1 ctrl", A_C1, 32'h0000_0000);
		wr(A_L0, 8'h05);
		wr(A_C0, 8'h3A);
		wait_cyc(45);
		ones(20, k);
		chk("buf width ch0", 32'h0000_0006, k);
		wr(A_H1, 8'h00);
		wr(A_L1, 8'h0A);
		wait_cyc(45);
		ones(20, k);
		chk("buf width ch1", 32'h0000_000B, k);
		$display("test link done");
	endtask : t_link
	// ************************************************************
	// run control
	// ************************************************************
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	// ceiling sits well above the roughly one thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run;
		end
	end
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		ext = 2'h0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_capture;
		t_compare;
		t_link;
		complete_run;
	end
endmodule : timer_channel_capture_compare_tb
